// file: design/dsi_drive_status.sv
// Drive status outputs, terminal routing and APB register file of the drive.
// Assumes synchronous inputs, one 10 MHz clock and an APB master on the bus side.
`timescale 1ns/1ps
module dsi_drive_status (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire dsi_pkg::dsi_apb_req_t       apbReq,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic                        forwardStartIn,
    input  wire logic                        reverseStartIn,
    input  wire logic                        powerOperableIn,
    input  wire logic                        faultDetectIn,
    input  wire logic                        motorOutputActiveIn,
    input  wire logic [15:0]                 outputCurrentPctIn,
    output dsi_pkg::dsi_status_t             statusOut,
    output logic [2:0]                       terminalOut,
    output logic                             relayNcClosedOut,
    output logic                             runCommandOut,
    output logic                             reverseDirOut,
    output logic                             irqOut
);
    import dsi_pkg::*;

    logic [LVL_W-1:0]  curLvl_q;
    logic [FREQ_W-1:0] freq_q;
    logic [SEL_W-1:0]  sel_q [NUM_TERM];
    logic [NUM_STAT-1:0] intStat_q;
    logic [NUM_STAT-1:0] intEn_q;
    logic              faultLatch_q;
    dsi_status_t       status_q;
    logic [NUM_TERM-1:0] term_q;
    logic              relay_q;
    logic              runCmd_q;
    logic              revDir_q;
    logic              irq_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [31:0]       prdata_q;

    // Bus phase decode; a transfer completes at the edge where pready is seen high.
    wire accessPh  = apbReq.psel & apbReq.penable;
    wire xferDone  = accessPh & pready_q;
    wire wrDone    = xferDone & apbReq.pwrite;
    wire [7:0] adr = apbReq.paddr;
    wire hitCtrl   = (adr == ADDR_CTRL);
    wire hitFreq   = (adr == ADDR_FREQ);
    wire hitLvl    = (adr == ADDR_CURLVL);
    wire hitSel0   = (adr == ADDR_SEL0);
    wire hitSel1   = (adr == ADDR_SEL1);
    wire hitSel2   = (adr == ADDR_SEL2);
    wire hitStat   = (adr == ADDR_STATUS);
    wire hitIStat  = (adr == ADDR_INTSTAT);
    wire hitIEn    = (adr == ADDR_INTEN);
    wire hitIClr   = (adr == ADDR_INTCLR);
    wire mapped    = hitCtrl | hitFreq | hitLvl | hitSel0 | hitSel1 | hitSel2
                   | hitStat | hitIStat | hitIEn | hitIClr;
    wire faultRstWr = wrDone & hitCtrl & apbReq.pwdata[CTRL_FAULT_RESET_BIT];
    wire [NUM_STAT-1:0] intClrWr = (wrDone & hitIClr) ? apbReq.pwdata[NUM_STAT-1:0]
                                                      : '0;

    // Read mux; write-only and unmapped words read as zero.
    logic [31:0] rdMux;
    always_comb begin
        rdMux = '0;
        if (hitFreq)  rdMux[FREQ_W-1:0]   = freq_q;
        if (hitLvl)   rdMux[LVL_W-1:0]    = curLvl_q;
        if (hitSel0)  rdMux[SEL_W-1:0]    = sel_q[0];
        if (hitSel1)  rdMux[SEL_W-1:0]    = sel_q[1];
        if (hitSel2)  rdMux[SEL_W-1:0]    = sel_q[2];
        if (hitStat)  rdMux[NUM_STAT-1:0] = status_q;
        if (hitIStat) rdMux[NUM_STAT-1:0] = intStat_q;
        if (hitIEn)   rdMux[NUM_STAT-1:0] = intEn_q;
    end

    // The slave answers one cycle into the access phase, so every transfer has
    // exactly one wait state; this keeps the read path registered.
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= accessPh & ~pready_q;
            pslverr_q <= accessPh & ~pready_q & ~mapped;
            prdata_q  <= (accessPh & ~pready_q & ~apbReq.pwrite) ? rdMux : '0;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clk) begin
        if (srst) begin
            curLvl_q <= CURLVL_RESET;                               // R8
            freq_q   <= FREQ_RESET;
            sel_q[0] <= SEL0_RESET;                                 // R2
            sel_q[1] <= SEL1_RESET;                                 // R5
            sel_q[2] <= SEL2_RESET;
            intEn_q  <= '0;
        end else if (wrDone) begin
            if (hitLvl)  curLvl_q <= apbReq.pwdata[LVL_W-1:0];     // R8
            if (hitFreq) freq_q   <= apbReq.pwdata[FREQ_W-1:0];
            if (hitSel0) sel_q[0] <= apbReq.pwdata[SEL_W-1:0];     // R9
            if (hitSel1) sel_q[1] <= apbReq.pwdata[SEL_W-1:0];     // R9
            if (hitSel2) sel_q[2] <= apbReq.pwdata[SEL_W-1:0];     // R9
            if (hitIEn)  intEn_q  <= apbReq.pwdata[NUM_STAT-1:0];
        end
    end

    // Drive state. Both start inputs at once is treated as stop, so the direction
    // is never ambiguous. Without a nonzero frequency command the drive stays idle.
    wire oneStart   = forwardStartIn ^ reverseStartIn;
    wire runCmdD    = oneStart & (freq_q != '0) & powerOperableIn
                    & ~faultLatch_q & ~faultDetectIn;              // R17
    wire faultD     = faultDetectIn | (faultLatch_q & ~faultRstWr);
    dsi_status_t statusD;
    assign statusD.fault   = faultD;                                // R1
    assign statusD.ready   = powerOperableIn & ~faultD;             // R4
    assign statusD.running = runCmdD | (motorOutputActiveIn & ~faultD); // R5 R6
    assign statusD.curDet  = statusD.running
                           & (outputCurrentPctIn > curLvl_q);      // R7 R8

    // The fault latch holds until software resets it; a new fault in the same
    // cycle as the reset wins, so a trip is never lost.
    always_ff @(posedge clk) begin
        if (srst) begin
            faultLatch_q <= 1'b0;
            status_q     <= '0;
            runCmd_q     <= 1'b0;
            revDir_q     <= 1'b0;
        end else begin
            faultLatch_q <= faultD;                                 // R1
            status_q     <= statusD;
            runCmd_q     <= runCmdD;                                // R17
            revDir_q     <= runCmdD ? reverseStartIn : revDir_q;
        end
    end

    // Terminal routing: each selector picks a status and its polarity; an
    // unknown code leaves the terminal inactive rather than guessing.
    logic [NUM_TERM-1:0] termD;
    for (genvar g = 0; g < NUM_TERM; g++) begin : gTerm
        wire [SEL_W-1:0] code = sel_q[g];
        assign termD[g] = ((code == CODE_FAULT_POS) &  statusD.fault)   // R10
                        | ((code == CODE_READY_POS) &  statusD.ready)   // R10
                        | ((code == CODE_RUN_POS)   &  statusD.running) // R10
                        | ((code == CODE_CUR_POS)   &  statusD.curDet)  // R10
                        | ((code == CODE_FAULT_NEG) & ~statusD.fault)   // R3 R11
                        | ((code == CODE_READY_NEG) & ~statusD.ready)   // R11
                        | ((code == CODE_RUN_NEG)   & ~statusD.running) // R11
                        | ((code == CODE_CUR_NEG)   & ~statusD.curDet); // R11
    end

    // Interrupt events: trip, ready gained, run ended, current detected.
    wire [NUM_STAT-1:0] evt;
    assign evt[0] = statusD.fault & ~status_q.fault;
    assign evt[1] = statusD.ready & ~status_q.ready;
    assign evt[2] = ~statusD.running & status_q.running;
    assign evt[3] = statusD.curDet & ~status_q.curDet;
    wire [NUM_STAT-1:0] intStatD = evt | (intStat_q & ~intClrWr);

    // Terminal, relay and interrupt flops; the relay coil follows its terminal so
    // the NC pair opens whenever that terminal is active.
    always_ff @(posedge clk) begin
        if (srst) begin
            term_q    <= '0;
            relay_q   <= 1'b1;
            intStat_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            term_q    <= termD;                                     // R9
            relay_q   <= ~termD[RELAY_TERM];                        // R2
            intStat_q <= intStatD;
            irq_q     <= |(intStatD & intEn_q);
        end
    end

    assign pready           = pready_q;
    assign prdata           = prdata_q;
    assign pslverr          = pslverr_q;
    assign statusOut        = status_q;
    assign terminalOut      = term_q;
    assign relayNcClosedOut = relay_q;
    assign runCommandOut    = runCmd_q;
    assign reverseDirOut    = revDir_q;
    assign irqOut           = irq_q;

    // Checks kept beside the logic they guard.
    fault_trip_a: assert property (@(posedge clk) disable iff (srst) // R1
        faultDetectIn |=> statusOut.fault)
        else $error("Fault detect did not raise the fault-trip status.");

    relay_open_a: assert property (@(posedge clk) disable iff (srst) // R2
        (sel_q[RELAY_TERM] == CODE_FAULT_POS) && faultDetectIn |=> !relayNcClosedOut)
        else $error("Relay NC pair stayed closed on a fault.");

    neg_logic_a: assert property (@(posedge clk) disable iff (srst) // R3
        $stable(sel_q[0]) && (sel_q[0] == CODE_FAULT_NEG) |=> terminalOut[0] != statusOut.fault)
        else $error("Negative fault logic not inverted.");

    ready_a: assert property (@(posedge clk) disable iff (srst) // R4
        powerOperableIn && !faultDetectIn && !faultLatch_q ##1 !faultRstWr
            |-> statusOut.ready)
        else $error("Ready missing while powered and operable.");

    running_hold_a: assert property (@(posedge clk) disable iff (srst) // R6
        statusOut.running && motorOutputActiveIn && !faultD |=> statusOut.running)
        else $error("Running dropped while motor output still active.");

    curdet_a: assert property (@(posedge clk) disable iff (srst) // R7
        statusOut.curDet |-> statusOut.running)
        else $error("Current detected while not running.");

    level_rst_a: assert property (@(posedge clk) // R8
        $past(srst) && !srst |-> curLvl_q == CURLVL_RESET)
        else $error("Detection level not at its reset default.");

    run_cmd_a: assert property (@(posedge clk) disable iff (srst) // R17
        runCommandOut |-> $past(freq_q) != '0 && $past(forwardStartIn ^ reverseStartIn))
        else $error("Drive ran without both frequency and start commands.");

    apb_answer_a: assert property (@(posedge clk) disable iff (srst)
        $rose(accessPh) |=> pready ##1 !pready)
        else $error("APB answer not exactly one cycle into access.");

    // Further checks on latch, status, routing, interrupt, bus, direction and start behaviour.

    // A latched trip survives until software resets it.
    fault_latch_a: assert property (@(posedge clk) disable iff (srst) // R1
        faultLatch_q && !faultRstWr |=> faultLatch_q)
        else $error("Fault latch lost without a reset write.");

    // A reset write with no new fault clears the latch.
    fault_clear_a: assert property (@(posedge clk) disable iff (srst) // R1
        faultRstWr && !faultDetectIn |=> !faultLatch_q)
        else $error("Fault latch not cleared by the reset write.");

    // Without power the drive is never ready.
    ready_drop_a: assert property (@(posedge clk) disable iff (srst) // R4
        !powerOperableIn |=> !statusOut.ready)
        else $error("Ready shown without power.");

    // A trip removes readiness at once.
    ready_fault_a: assert property (@(posedge clk) disable iff (srst) // R4
        faultD |=> !statusOut.ready)
        else $error("Ready shown while tripped.");

    // Powered and untripped means ready on the next edge.
    ready_rise_a: assert property (@(posedge clk) disable iff (srst) // R4
        powerOperableIn && !faultD |=> statusOut.ready)
        else $error("Ready missing while operable.");

    // An accepted run command shows as running and drives the stage.
    run_start_a: assert property (@(posedge clk) disable iff (srst) // R5
        runCmdD |=> statusOut.running && runCommandOut)
        else $error("Run command not reflected in running status.");

    // No command and no output means running has ended.
    run_stop_a: assert property (@(posedge clk) disable iff (srst) // R6
        !runCmdD && !motorOutputActiveIn |=> !statusOut.running)
        else $error("Running held after output stopped.");

    // Current above the level while running is reported.
    curdet_level_a: assert property (@(posedge clk) disable iff (srst) // R7 R8
        statusD.running && (outputCurrentPctIn > curLvl_q) |=> statusOut.curDet)
        else $error("Current above level not detected.");

    // Current at or below the level is never reported.
    curdet_below_a: assert property (@(posedge clk) disable iff (srst) // R7 R8
        outputCurrentPctIn <= curLvl_q |=> !statusOut.curDet)
        else $error("Current detected at or below the level.");

    // Positive running code copies running onto terminal 1.
    pos_run_a: assert property (@(posedge clk) disable iff (srst) // R10
        sel_q[1] == CODE_RUN_POS |=> terminalOut[1] == statusOut.running)
        else $error("Positive running code not followed.");

    // Negative running code inverts running on terminal 1.
    neg_run_a: assert property (@(posedge clk) disable iff (srst) // R11
        sel_q[1] == CODE_RUN_NEG |=> terminalOut[1] != statusOut.running)
        else $error("Negative running code not inverted.");

    // Positive current code copies detection onto terminal 2.
    pos_cur_a: assert property (@(posedge clk) disable iff (srst) // R10
        sel_q[2] == CODE_CUR_POS |=> terminalOut[2] == statusOut.curDet)
        else $error("Positive current code not followed.");

    // Negative ready code inverts readiness on terminal 2.
    neg_ready_a: assert property (@(posedge clk) disable iff (srst) // R11
        sel_q[2] == CODE_READY_NEG |=> terminalOut[2] != statusOut.ready)
        else $error("Negative ready code not inverted.");

    // Positive ready code copies readiness onto terminal 2.
    pos_ready_a: assert property (@(posedge clk) disable iff (srst) // R10
        sel_q[2] == CODE_READY_POS |=> terminalOut[2] == statusOut.ready)
        else $error("Positive ready code not followed.");

    // The interrupt line mirrors enabled sticky bits.
    irq_level_a: assert property (@(posedge clk) disable iff (srst)
        irqOut == |(intStat_q & $past(intEn_q)))
        else $error("Interrupt line disagrees with enabled status.");

    // A trip event always sets its sticky bit.
    fault_event_a: assert property (@(posedge clk) disable iff (srst) // R1
        evt[0] |=> intStat_q[0])
        else $error("Trip event not recorded.");

    // A sticky trip bit stays until cleared.
    fault_sticky_a: assert property (@(posedge clk) disable iff (srst)
        intStat_q[0] && !intClrWr[0] |=> intStat_q[0])
        else $error("Trip status bit lost without a clear.");

    // A clear with no new event empties the bit.
    int_clear_a: assert property (@(posedge clk) disable iff (srst)
        intClrWr[0] && !evt[0] |=> !intStat_q[0])
        else $error("Trip status bit not cleared.");

    // Unmapped addresses are answered with an error.
    apb_err_a: assert property (@(posedge clk) disable iff (srst)
        accessPh && !pready_q && !mapped |=> pslverr)
        else $error("Unmapped access not flagged.");

    // A level read returns the stored level in the low bits.
    apb_rdata_a: assert property (@(posedge clk) disable iff (srst) // R8
        accessPh && !pready_q && !apbReq.pwrite && hitLvl |=> prdata == 32'(curLvl_q))
        else $error("Level read returned wrong data.");

    // Ready is never raised outside an access phase.
    apb_idle_a: assert property (@(posedge clk) disable iff (srst)
        !accessPh |=> !pready)
        else $error("Ready raised with no access.");

    // Direction only changes with an accepted run command.
    dir_hold_a: assert property (@(posedge clk) disable iff (srst)
        !runCmdD |=> $stable(reverseDirOut))
        else $error("Direction changed without a run command.");

    // Both start inputs together never run the drive.
    both_start_a: assert property (@(posedge clk) disable iff (srst) // R17
        forwardStartIn && reverseStartIn |=> !runCommandOut)
        else $error("Drive ran with both start inputs high.");

endmodule

// file: design/dsi_pkg.sv
// Constants, register map and carrier types of the drive status interlock block.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
// Summary of operation
// (R1) Fault trip raises the fault-trip status output.
// (R2) Default relay terminal opens its NC pair on fault.
// (R3) Negative logic: active when normal, released on fault.
// (R4) Ready output asserts once powered and operable.
// (R5) Running output asserts while running, default terminal.
// (R6) Running holds through deceleration until output stops.
// (R7) Current-detected asserts when running above set level.
// (R8) Detection level defaults to 150 percent, adjustable.
// (R9) Three terminal selectors pick signal and polarity.
// (R10) Positive codes: 99, 11, 0, 12.
// (R11) Negative codes: 199, 111, 100, 112, inverted.
// (R12) Controller checks ready after power-on.
// (R13) Controller checks running against start inputs.
// (R14) Controller checks current-detected against start inputs.
// (R15) Backup compares start with measured speed or current.
// (R16) Backup compares commanded speed with measured speed.
// (R17) Drive runs only with frequency and start commands.
// (R18) Interlock alarms on mismatch beyond deceleration allowance.
package dsi_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_FREQ    = 8'h04;
    localparam logic [7:0] ADDR_CURLVL  = 8'h08;
    localparam logic [7:0] ADDR_SEL0    = 8'h0C;
    localparam logic [7:0] ADDR_SEL1    = 8'h10;
    localparam logic [7:0] ADDR_SEL2    = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_INTSTAT = 8'h1C;
    localparam logic [7:0] ADDR_INTEN   = 8'h20;
    localparam logic [7:0] ADDR_INTCLR  = 8'h24;

    // Field positions and widths.
    localparam int          CTRL_FAULT_RESET_BIT = 0;
    localparam int          SEL_W                = 8;
    localparam int          LVL_W                = 16;
    localparam int          FREQ_W               = 16;
    localparam int          NUM_TERM             = 3;
    localparam int          NUM_STAT             = 4;
    localparam int          RELAY_TERM           = 0;

    // Reset values.
    localparam logic [LVL_W-1:0]  CURLVL_RESET = 16'h0096;  // 150 percent of rated current.
    localparam logic [FREQ_W-1:0] FREQ_RESET   = 16'h0000;

    // Terminal function selection codes.
    localparam logic [SEL_W-1:0] CODE_FAULT_POS = 8'h63;    // 99
    localparam logic [SEL_W-1:0] CODE_READY_POS = 8'h0B;    // 11
    localparam logic [SEL_W-1:0] CODE_RUN_POS   = 8'h00;    // 0
    localparam logic [SEL_W-1:0] CODE_CUR_POS   = 8'h0C;    // 12
    localparam logic [SEL_W-1:0] CODE_FAULT_NEG = 8'hC7;    // 199
    localparam logic [SEL_W-1:0] CODE_READY_NEG = 8'h6F;    // 111
    localparam logic [SEL_W-1:0] CODE_RUN_NEG   = 8'h64;    // 100
    localparam logic [SEL_W-1:0] CODE_CUR_NEG   = 8'h70;    // 112

    // Terminal 0, 1 and 2 defaults; any of the codes above is legal.
    localparam logic [SEL_W-1:0] SEL0_RESET = CODE_FAULT_POS;
    localparam logic [SEL_W-1:0] SEL1_RESET = CODE_RUN_POS;
    localparam logic [SEL_W-1:0] SEL2_RESET = CODE_CUR_POS;

    // Drive status carrier; bit order is also the STATUS and interrupt layout.
    typedef struct packed {
        logic curDet;
        logic running;
        logic ready;
        logic fault;
    } dsi_status_t;

    // APB request as seen by the slave.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } dsi_apb_req_t;

endpackage

// file: tb/dsi_seq_ctrl.sv
// Model of the external sequence controller that cross-checks the drive status.
// Assumes start inputs and drive status share the one system clock.
`timescale 1ns/1ps
module dsi_seq_ctrl #(
    parameter int DECEL_ALLOW = 16
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 forwardStartIn,
    input  wire logic                 reverseStartIn,
    input  wire logic                 powerOperableIn,
    input  wire dsi_pkg::dsi_status_t statusIn,
    input  wire logic                 measRunIn,
    input  wire logic [15:0]          cmdSpeedIn,
    output logic                      alarmOut
);
    import dsi_pkg::*;
    logic       startCmd;
    logic       disagree;
    logic [7:0] mismatchCnt_q;
    // Both start inputs high is a stop, so start is their exclusive or.
    assign startCmd = forwardStartIn ^ reverseStartIn;
    // Ready must follow power and running must follow start.
    assign disagree = (powerOperableIn & ~statusIn.ready)
                    | (startCmd != statusIn.running)
                    | (statusIn.curDet & ~startCmd)
                    | (startCmd != measRunIn)
                    | (startCmd & (cmdSpeedIn != 16'h0000) & ~measRunIn);
    // Consecutive disagreeing cycles; the allowance hides deceleration.
    always_ff @(posedge clk) begin
        if (srst || !disagree) begin
            mismatchCnt_q <= 8'h00;
        end else if (mismatchCnt_q != 8'hFF) begin
            mismatchCnt_q <= mismatchCnt_q + 8'h01;
        end
    end
    // Alarm only once the mismatch outlasts the allowance.
    assign alarmOut = 32'(mismatchCnt_q) > DECEL_ALLOW;
endmodule

// file: tb/drive_status_interlock_tb.sv
// Self-checking bench of the drive status block with an interlock model beside it.
// Assumes the design package is compiled first; drives APB and the drive pins.
`timescale 1ns/1ps
module drive_status_interlock_tb;
    import dsi_pkg::*;
    logic         clk     = 1'b0;
    logic         srst    = 1'b1;
    dsi_apb_req_t req     = '0;
    logic         fwd     = 1'b0;
    logic         rev     = 1'b0;
    logic         pwrOk   = 1'b0;
    logic         faultIn = 1'b0;
    logic         motAct  = 1'b0;
    logic [15:0]  curPct  = 16'h0000;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    dsi_status_t  status;
    logic [2:0]   term;
    logic         relayNc;
    logic         runCmd;
    logic         revDir;
    logic         irq;
    logic         alarm;
    logic [31:0]  rd;
    logic         err;
    logic [15:0]  cmdSpd  = 16'h0000;
    int           err_total = 0;
    int           n_tests   = 0;
    // Free-running 10 MHz clock.
    initial begin
        forever #50 clk = ~clk;
    end
    dsi_drive_status dut_u (.clk(clk), .srst(srst), .apbReq(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .forwardStartIn(fwd), .reverseStartIn(rev),
        .powerOperableIn(pwrOk), .faultDetectIn(faultIn), .motorOutputActiveIn(motAct),
        .outputCurrentPctIn(curPct), .statusOut(status), .terminalOut(term),
        .relayNcClosedOut(relayNc), .runCommandOut(runCmd), .reverseDirOut(revDir),
        .irqOut(irq));
    dsi_seq_ctrl #(.DECEL_ALLOW(16)) ctrl_u (.clk(clk), .srst(srst), .forwardStartIn(fwd),
        .reverseStartIn(rev), .powerOperableIn(pwrOk), .statusIn(status),
        .measRunIn(motAct), .cmdSpeedIn(cmdSpd), .alarmOut(alarm));
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One APB transfer; the wait for pready is bounded so a dead slave ends the run.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge clk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wdata;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            final_report();
        end else begin
            rd = prdata;
            err = pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask
    // Lets an input change be sampled and the registered outputs land.
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic tRegs;
        chk(relayNc, 1'b1);
        apb(1'b0, ADDR_SEL0, 32'h0);
        chk(rd, 32'h0000_0063);
        apb(1'b0, ADDR_SEL1, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, ADDR_SEL2, 32'h0);
        chk(rd, 32'h0000_000C);
        apb(1'b0, ADDR_CURLVL, 32'h0);
        chk(rd, 32'h0000_0096);
        apb(1'b1, 8'h28, 32'hFFFF_FFFF);
        chk(err, 1'b1);
    endtask
    task automatic tReady;
        @(posedge clk);
        pwrOk <= 1'b1;
        settle();
        chk(status.ready, 1'b1);
    endtask
    // Start without a speed command must not run; then forward, decel, reverse.
    task automatic tRun;
        @(posedge clk);
        fwd <= 1'b1;
        settle();
        chk(status.running, 1'b0);
        apb(1'b1, ADDR_FREQ, 32'h0000_0100);
        @(posedge clk);
        motAct <= 1'b1;
        cmdSpd <= 16'h0100;
        settle();
        chk({status.running, term[1], runCmd, revDir}, 4'b1110);
        @(posedge clk);
        fwd <= 1'b0;
        settle();
        chk({status.running, runCmd}, 2'b10);
        @(posedge clk);
        motAct <= 1'b0;
        settle();
        chk(status.running, 1'b0);
        @(posedge clk);
        rev <= 1'b1;
        curPct <= 16'h0096;
        settle();
        chk({status.running, revDir, status.curDet}, 3'b110);
        @(posedge clk);
        curPct <= 16'h0097;
        settle();
        chk(status.curDet, 1'b1);
        apb(1'b1, ADDR_CURLVL, 32'h0000_0014);
        @(posedge clk);
        curPct <= 16'h0014;
        settle();
        chk(status.curDet, 1'b0);
        @(posedge clk);
        curPct <= 16'h0015;
        settle();
        chk({status.curDet, term[2]}, 2'b11);
        @(posedge clk);
        rev <= 1'b0;
        settle();
        chk({status.running, status.curDet}, 2'b00);
        chk(alarm, 1'b0);
    endtask
    // A fault pulse latches, interrupts, and survives until the latch is cleared.
    task automatic tFault;
        apb(1'b1, ADDR_INTEN, 32'h1);
        chk(irq, 1'b0);
        @(posedge clk);
        faultIn <= 1'b1;
        @(posedge clk);
        faultIn <= 1'b0;
        settle();
        chk({status.fault, term[0], relayNc, status.ready, irq}, 5'b11001);
        apb(1'b0, ADDR_INTSTAT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        repeat (20) @(posedge clk);
        #1;
        chk(alarm, 1'b1);
        apb(1'b1, ADDR_INTCLR, 32'h1);
        settle();
        chk({irq, status.fault}, 2'b01);
        apb(1'b1, ADDR_CTRL, 32'h1);
        settle();
        chk({status.fault, relayNc, status.ready}, 3'b011);
    endtask
    // Every code on terminal 2 while only ready is active.
    task automatic tCodes;
        logic [7:0] codes [8];
        logic       exps  [8];
        codes = '{8'h63, 8'hC7, 8'h0B, 8'h6F, 8'h00, 8'h64, 8'h0C, 8'h70};
        exps  = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_SEL2, {24'h0, codes[i]});
            settle();
            chk(term[2], exps[i]);
        end
        apb(1'b1, ADDR_SEL0, {24'h0, CODE_FAULT_NEG});
        settle();
        chk({term[0], relayNc}, 2'b10);
        apb(1'b1, ADDR_SEL0, {24'h0, CODE_FAULT_POS});
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        settle();
        tRegs();
        tReady();
        tRun();
        tFault();
        tCodes();
        final_report();
    end
endmodule
